// ---- rtl/tce_pkg.sv ----
// Shared constants and types of the transfer controller end-state block.
// Assumes a 32-bit memory bus with byte addresses and eight sources.
package tce_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NSRC = 8;
	localparam int VEC_W = 3;
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 16;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_VBASE = 8'h00;
	localparam logic [7:0] OFF_START = 8'h04;
	localparam logic [7:0] OFF_ADMOD = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_ENABLE = 8'h40;
	localparam logic [31:0] VBASE_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Transfer information layout
	// ----------------------------------------------------------------
	localparam int INFO_MRA_LO = 24;
	localparam int INFO_MRB_LO = 16;
	localparam logic [1:0] INFO_LAST = 2'h3;
	localparam logic [31:0] INFO_BYTES = 32'h0000_0010;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	localparam int SHORT_ADDR_W = 24;
	localparam int MRA_MD_HI = 7;
	localparam int MRA_MD_LO = 6;
	localparam int MRA_SZ_HI = 5;
	localparam int MRA_SZ_LO = 4;
	localparam int MRA_SM_HI = 3;
	localparam int MRA_SM_LO = 2;
	localparam int MRB_CHAIN_ENABLE_BIT = 7;
	localparam int MRB_CHAIN_CONDITION_BIT = 6;
	localparam int MRB_DTS = 4;
	localparam int MRB_DM_HI = 3;
	localparam int MRB_DM_LO = 2;
	localparam logic [1:0] MD_NORMAL = 2'h0;
	localparam logic [1:0] MD_REPEAT = 2'h1;
	localparam logic [1:0] MD_BLOCK = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE, ST_VEC, ST_INFO, ST_RD, ST_WR, ST_END, ST_WB, ST_FIN
	} tce_state_type;

endpackage : tce_pkg

// ---- rtl/tce_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock; ce low freezes it.
`timescale 1ns/100ps
`default_nettype none
module tce_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} tce_fifo_state_type;

	tce_fifo_state_type r_q;
	tce_fifo_state_type r_d;
	logic push;
	logic pop;

	assign in_ready = r_q.cnt != (AW+1)'(DEPTH);
	assign out_valid = r_q.cnt != '0;
	assign out_data = r_q.mem[r_q.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		r_d = r_q;
		if (push)
		begin
			r_d.mem[r_q.wp] = in_data;
			r_d.wp = r_q.wp + 1'b1;
		end
		if (pop)
			r_d.rp = r_q.rp + 1'b1;
		if (push && !pop)
			r_d.cnt = r_q.cnt + 1'b1;
		else if (pop && !push)
			r_d.cnt = r_q.cnt - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			r_q <= '0;
		else if (ce)
			r_q <= r_d;
	end
endmodule : tce_fifo
`default_nettype wire

// ---- rtl/tce_arb.sv ----
// Picks the lowest-numbered pending activation source.
// Assumes requests come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tce_arb (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [tce_pkg::NSRC-1:0] req,
	output logic valid,
	output logic [tce_pkg::VEC_W-1:0] vec
);
	import tce_pkg::*;

	typedef struct packed {
		logic valid;
		logic [VEC_W-1:0] vec;
	} tce_arb_state_type;

	tce_arb_state_type r_q;
	tce_arb_state_type r_d;

	assign valid = r_q.valid;
	assign vec = r_q.vec;

	always_comb
	begin
		r_d = '0;
		for (int i = NSRC - 1; i >= 0; i--)
			if (req[i])
			begin
				r_d.valid = 1'b1;
				r_d.vec = VEC_W'(i);
			end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			r_q <= '0;
		else if (ce)
			r_q <= r_d;
	end
endmodule : tce_arb
`default_nettype wire

// ---- rtl/tce_ctrl.sv ----
// Transfer controller: vector fetch, unit/repeat/block moves, end state.
// Assumes an Avalon-MM register master and a memory bus that holds
// mem_ack high for one cycle per accepted request.
`timescale 1ns/100ps
`default_nettype none
module tce_ctrl (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [tce_pkg::NSRC-1:0] act_req,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	output logic busy
);
	import tce_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		tce_state_type st;
		logic waitreq;
		logic [31:0] rdata;
		logic [NSRC-1:0] en;
		logic [NSRC-1:0] pend;
		logic [31:0] vbase;
		logic start;
		logic short_mode;
		logic [VEC_W-1:0] vec;
		logic [31:0] ptr;
		logic [1:0] idx;
		logic [7:0] mode_reg_a;
		logic [7:0] mode_reg_b;
		logic [31:0] sar;
		logic [31:0] dar;
		logic [15:0] transfer_count_reg;
		logic [15:0] block_count_reg;
		logic [8:0] rd_left;
		logic [8:0] wr_left;
		logic done;
		logic mreq;
		logic mwe;
		logic [31:0] maddr;
		logic [31:0] mwdata;
		logic busy;
	} tce_ctl_type;

	tce_ctl_type r_q;
	tce_ctl_type r_d;

	logic arb_valid;
	logic [VEC_W-1:0] arb_vec;
	logic f_in_valid;
	logic f_in_ready;
	logic f_out_valid;
	logic f_out_ready;
	logic [31:0] f_out_data;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] addr_step(logic [31:0] a,
		logic [1:0] am, logic [1:0] sz);
		logic [31:0] s;
		s = 32'h1 << sz;
		if (!am[1])
			return a;
		else if (am[0])
			return a - s;
		else
			return a + s;
	endfunction : addr_step

	// Undo n steps, giving back the area's initial address
	function automatic logic [31:0] addr_restore(logic [31:0] a,
		logic [1:0] am, logic [1:0] sz, logic [8:0] n);
		logic [31:0] amt;
		amt = {23'h0, n} << sz;
		if (!am[1])
			return a;
		else if (am[0])
			return a + amt;
		else
			return a - amt;
	endfunction : addr_restore

	// Zero stands for 256 units
	function automatic logic [8:0] units(logic [7:0] b);
		return (b == 8'h00) ? 9'h100 : {1'b0, b};
	endfunction : units

	function automatic logic [31:0] bmask(logic [31:0] old,
		logic [31:0] wd, logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				res[i*8 +: 8] = wd[i*8 +: 8];
		return res;
	endfunction : bmask

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	tce_arb u_arb (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.req(r_q.pend & r_q.en),
		.valid(arb_valid),
		.vec(arb_vec)
	);

	tce_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(mem_rdata),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data)
	);

	assign f_in_valid = (r_q.st == ST_RD) && mem_ack && r_q.mreq;
	assign f_out_ready = (r_q.st == ST_WR) && mem_ack && r_q.mreq;

	assign avs_readdata = r_q.rdata;
	assign avs_waitrequest = r_q.waitreq;
	assign mem_req = r_q.mreq;
	assign mem_we = r_q.mwe;
	assign mem_addr = r_q.maddr;
	assign mem_wdata = r_q.mwdata;
	assign busy = r_q.busy;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [1:0] md;
		logic [1:0] sz;
		logic [1:0] sm;
		logic [1:0] dm;
		logic [VEC_W-1:0] ev;
		logic [NSRC-1:0] clr;
		logic [15:0] cnt;
		md = r_q.mode_reg_a[MRA_MD_HI:MRA_MD_LO];
		sz = r_q.mode_reg_a[MRA_SZ_HI:MRA_SZ_LO];
		sm = r_q.mode_reg_a[MRA_SM_HI:MRA_SM_LO];
		dm = r_q.mode_reg_b[MRB_DM_HI:MRB_DM_LO];
		ev = avs_address[VEC_W+1:2];
		clr = '0;
		cnt = r_q.transfer_count_reg;
		r_d = r_q;

		case (r_q.st)
			ST_IDLE:
			begin
				if (arb_valid && r_q.start
					&& r_q.en[arb_vec] && r_q.pend[arb_vec])
				begin
					r_d.vec = arb_vec;
					clr[arb_vec] = 1'b1;
					r_d.maddr = r_q.vbase + ({29'h0, arb_vec} << 2);
					r_d.mreq = 1'b1;
					r_d.mwe = 1'b0;
					r_d.st = ST_VEC;
				end
			end
			ST_VEC:
			begin
				if (mem_ack)
				begin
					// Short mode holds 24-bit pointers, sign extended
					if (r_q.short_mode)
						r_d.ptr = {{(32-SHORT_ADDR_W){mem_rdata[23]}},
							mem_rdata[SHORT_ADDR_W-1:0]};
					else
						r_d.ptr = mem_rdata;
					r_d.maddr = r_d.ptr;
					r_d.idx = 2'h0;
					r_d.st = ST_INFO;
				end
			end
			ST_INFO:
			begin
				if (mem_ack)
				begin
					case (r_q.idx)
						2'h0:
						begin
							r_d.mode_reg_a = mem_rdata[INFO_MRA_LO +: 8];
							r_d.mode_reg_b = mem_rdata[INFO_MRB_LO +: 8];
						end
						2'h1: r_d.sar = mem_rdata;
						2'h2: r_d.dar = mem_rdata;
						default:
						begin
							r_d.transfer_count_reg = mem_rdata[31:16];
							r_d.block_count_reg = mem_rdata[15:0];
						end
					endcase
					if (r_q.idx == INFO_LAST)
					begin
						r_d.mreq = 1'b0;
						// One unit per activation except a whole block
						if (md == MD_BLOCK)
							r_d.rd_left = units(mem_rdata[31:24]);
						else
							r_d.rd_left = 9'h001;
						r_d.wr_left = r_d.rd_left;
						r_d.st = ST_RD;
					end
					else
					begin
						r_d.idx = r_q.idx + 2'h1;
						r_d.maddr = r_q.maddr + WORD_BYTES;
					end
				end
			end
			ST_RD:
			begin
				if (r_q.mreq)
				begin
					if (mem_ack)
					begin
						r_d.mreq = 1'b0;
						r_d.sar = addr_step(r_q.sar, sm, sz);
						r_d.rd_left = r_q.rd_left - 9'h001;
					end
				end
				else if (r_q.rd_left != 9'h000 && f_in_ready)
				begin
					r_d.mreq = 1'b1;
					r_d.mwe = 1'b0;
					r_d.maddr = r_q.sar;
				end
				else
					r_d.st = ST_WR;
			end
			ST_WR:
			begin
				if (r_q.mreq)
				begin
					if (mem_ack)
					begin
						r_d.mreq = 1'b0;
						r_d.dar = addr_step(r_q.dar, dm, sz);
						r_d.wr_left = r_q.wr_left - 9'h001;
					end
				end
				else if (r_q.wr_left == 9'h000)
					r_d.st = ST_END;
				else if (f_out_valid)
				begin
					r_d.mreq = 1'b1;
					r_d.mwe = 1'b1;
					r_d.maddr = r_q.dar;
					r_d.mwdata = f_out_data;
				end
				else
					r_d.st = ST_RD;
			end
			ST_END:
			begin
				r_d.done = 1'b0;
				if (md == MD_REPEAT)
				begin
					cnt[7:0] = r_q.transfer_count_reg[7:0] - 8'h01;
					if (cnt[7:0] == 8'h00)
					begin
						cnt[7:0] = r_q.transfer_count_reg[15:8];
						if (r_q.mode_reg_b[MRB_DTS])
							r_d.sar = addr_restore(r_q.sar, sm, sz,
								units(r_q.transfer_count_reg[15:8]));
						else
							r_d.dar = addr_restore(r_q.dar, dm, sz,
								units(r_q.transfer_count_reg[15:8]));
					end
					r_d.transfer_count_reg = cnt;
				end
				else if (md == MD_BLOCK)
				begin
					// Block size counter untouched, so it is already restored
					if (r_q.mode_reg_b[MRB_DTS])
						r_d.sar = addr_restore(r_q.sar, sm, sz,
							units(r_q.transfer_count_reg[15:8]));
					else
						r_d.dar = addr_restore(r_q.dar, dm, sz,
							units(r_q.transfer_count_reg[15:8]));
					r_d.block_count_reg = r_q.block_count_reg - 16'h0001;
					r_d.done = r_d.block_count_reg == 16'h0000;
				end
				else
				begin
					r_d.transfer_count_reg = r_q.transfer_count_reg - 16'h0001;
					r_d.done = r_d.transfer_count_reg == 16'h0000;
				end
				// Mode word is never written back
				r_d.idx = 2'h1;
				r_d.maddr = r_q.ptr + WORD_BYTES;
				r_d.mwdata = r_d.sar;
				r_d.mreq = 1'b1;
				r_d.mwe = 1'b1;
				r_d.st = ST_WB;
			end
			ST_WB:
			begin
				if (mem_ack)
				begin
					if (r_q.idx == INFO_LAST)
					begin
						r_d.mreq = 1'b0;
						r_d.st = ST_FIN;
					end
					else
					begin
						r_d.idx = r_q.idx + 2'h1;
						r_d.maddr = r_q.maddr + WORD_BYTES;
						r_d.mwdata = (r_q.idx == 2'h1) ? r_q.dar
							: {r_q.transfer_count_reg, r_q.block_count_reg};
					end
				end
			end
			default:
			begin
				// Condition bit set chains only once the count is spent
				if (r_q.mode_reg_b[MRB_CHAIN_ENABLE_BIT]
					&& (!r_q.mode_reg_b[MRB_CHAIN_CONDITION_BIT] || r_q.done))
				begin
					r_d.ptr = r_q.ptr + INFO_BYTES;
					r_d.maddr = r_d.ptr;
					r_d.idx = 2'h0;
					r_d.mreq = 1'b1;
					r_d.mwe = 1'b0;
					r_d.st = ST_INFO;
				end
				else
				begin
					if (r_q.done)
						r_d.en[r_q.vec] = 1'b0;
					r_d.st = ST_IDLE;
				end
			end
		endcase

		// A request in the cycle its pending bit clears is kept
		r_d.pend = (r_q.pend & ~clr) | (act_req & r_q.en);
		r_d.busy = r_d.st != ST_IDLE;

		// ------------------------------------------------------------
		// Avalon slave: one wait cycle, then the access completes
		// ------------------------------------------------------------
		if ((avs_read || avs_write) && r_q.waitreq)
		begin
			r_d.waitreq = 1'b0;
			r_d.rdata = 32'h0000_0000;
			if (!avs_read)
				r_d.rdata = 32'h0000_0000;
			else if (avs_address == OFF_VBASE)
				r_d.rdata = r_q.vbase;
			else if (avs_address == OFF_START)
				r_d.rdata = {31'h0, r_q.start};
			else if (avs_address == OFF_ADMOD)
				r_d.rdata = {31'h0, r_q.short_mode};
			else if (avs_address == OFF_STATUS)
				r_d.rdata = {16'h0, r_q.pend, 3'h0, r_q.busy,
					1'b0, r_q.vec};
			else if (avs_address[7:5] == OFF_ENABLE[7:5]
				&& avs_address[1:0] == 2'h0)
				r_d.rdata = {31'h0, r_q.en[ev]};
		end
		else if (!r_q.waitreq)
		begin
			r_d.waitreq = 1'b1;
			if (avs_write)
			begin
				if (avs_address == OFF_VBASE)
					r_d.vbase = bmask(r_q.vbase, avs_writedata,
						avs_byteenable);
				else if (avs_address == OFF_START && avs_byteenable[0])
					r_d.start = avs_writedata[0];
				else if (avs_address == OFF_ADMOD && avs_byteenable[0])
					r_d.short_mode = avs_writedata[0];
				else if (avs_address[7:5] == OFF_ENABLE[7:5]
					&& avs_address[1:0] == 2'h0 && avs_byteenable[0])
					r_d.en[ev] = avs_writedata[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			r_q <= '0;
			r_q.st <= ST_IDLE;
			r_q.waitreq <= 1'b1;
			r_q.vbase <= VBASE_RST;
		end
		else if (ce)
			r_q <= r_d;
	end
endmodule : tce_ctrl
`default_nettype wire

// ---- tb/tce_ctrl_properties.sv ----
// Port-level checks of the transfer controller.
// Assumes one clock and a master keeping the Avalon rules.
`timescale 1ns/100ps
`default_nettype none
module tce_ctrl_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// --------
	// Properties
	// --------
	property p_one_wait;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait too long");
	property p_wait_pulse;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("wait low");
	property p_unmapped;
		avs_read && !avs_waitrequest && avs_address == 8'h20
			|-> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped data");
	property p_req_hold;
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
			&& $stable(mem_we) && $stable(mem_wdata);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("req moved");
	property p_first_rd;
		$rose(busy) |-> ##[0:2] (mem_req && !mem_we);
	endproperty
	a_first_rd: assert property (p_first_rd) else $error("no vector read");
	property p_idle;
		!busy |-> !mem_req;
	endproperty
	a_idle: assert property (p_idle) else $error("req while idle");
	property p_busy_end;
		$rose(busy) |-> ##[1:1000] !busy;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("run too long");
	property p_ack_moves;
		mem_req && mem_ack |=> !mem_req || !$stable(mem_addr)
			|| !$stable(mem_we);
	endproperty
	a_ack_moves: assert property (p_ack_moves) else $error("req repeated");
endmodule : tce_ctrl_chk
bind tce_ctrl tce_ctrl_chk u_chk (.clk, .reset_n, .avs_address, .avs_read,
	.avs_write, .avs_readdata, .avs_waitrequest, .mem_req, .mem_we,
	.mem_addr, .mem_wdata, .mem_ack, .busy);
`default_nettype wire

// ---- tb/tce_mem_model.sv ----
// Word memory on the controller's memory bus, 256 words.
// Assumes the bench loads and inspects m directly.
`timescale 1ns/100ps
`default_nettype none
module tce_mem_model (
	input wire logic clk,
	input wire logic [1:0] slow,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ack
);
	logic [31:0] m [0:255];
	logic [1:0] cnt_q = 2'h0;
	// Slow only changes while idle
	assign mem_ack = mem_req && (cnt_q == slow);
	// Inverted word outside the ack cycle, never a stale match
	assign mem_rdata = mem_ack ? m[mem_addr[9:2]] : ~m[mem_addr[9:2]];
	always @(posedge clk)
	begin
		if (mem_ack)
		begin
			cnt_q <= 2'h0;
			if (mem_we)
				m[mem_addr[9:2]] <= mem_wdata;
		end
		else if (mem_req)
			cnt_q <= cnt_q + 2'h1;
	end
endmodule : tce_mem_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the transfer controller end state.
// Assumes vector base 0 and the memory model on the memory bus.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import tce_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic ce = 1'b1;
	logic [NSRC-1:0] act_req = 8'h0;
	logic [7:0] avs_address = 8'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [1:0] slow = 2'h0;
	logic [31:0] avs_readdata, mem_addr, mem_wdata, mem_rdata, rq;
	logic avs_waitrequest, mem_req, mem_we, mem_ack, busy;
	int miscompares = 0;
	int checked = 0;
	always #2 clk = ~clk;
	tce_ctrl dut (.clk, .reset_n, .ce, .act_req, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ack, .busy);
	tce_mem_model mem (.clk, .slow, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ack);
	// --------
	// Tasks
	// --------
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		rq = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 20)
		begin
			chk("bus wait", 32'h0, 32'h1);
			results;
		end
	endtask : bus
	task rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, rq);
	endtask : rchk
	task en(input int s, input logic e);
		rchk(OFF_ENABLE + 8'(s * 4), {31'h0, e});
	endtask : en
	task info(input int p, input logic [7:0] ma, input logic [7:0] mb,
		input logic [31:0] sa, input logic [31:0] da, input logic [31:0] w3);
		mem.m[p] = {ma, mb, 16'h0};
		mem.m[p + 1] = sa;
		mem.m[p + 2] = da;
		mem.m[p + 3] = w3;
	endtask : info
	task arm(input int s, input int p);
		mem.m[s] = 32'(p * 4);
		bus(1'b1, OFF_ENABLE + 8'(s * 4), 32'h1);
	endtask : arm
	task fire(input int s);
		int n;
		n = 0;
		@(posedge clk);
		act_req[s] <= 1'b1;
		@(posedge clk);
		act_req[s] <= 1'b0;
		while (busy !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		// A run that never starts is a failure, not a pass
		if (n >= 20)
		begin
			chk("busy rise", 32'h1, {31'h0, busy});
			results;
		end
		n = 0;
		while (busy !== 1'b0 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000)
		begin
			chk("busy fall", 32'h0, {31'h0, busy});
			results;
		end
	endtask : fire
	// --------
	// Scenarios
	// --------
	task t_regs;
		rchk(OFF_VBASE, VBASE_RST);
		en(7, 1'b0);
		bus(1'b1, 8'h20, 32'hffff_ffff);
		rchk(8'h20, 32'h0);
		bus(1'b1, OFF_ENABLE + 8'h1c, 32'h1);
		en(7, 1'b1);
		en(6, 1'b0);
		bus(1'b1, OFF_START, 32'h1);
	endtask : t_regs
	task t_normal;
		info('h10, 8'h28, 8'h08, 32'h100, 32'h200, 32'h0003_0000);
		arm(1, 'h10);
		fire(1);
		en(1, 1'b1);
		fire(1);
		fire(1);
		en(1, 1'b0);
		chk("n mode", 32'h2808_0000, mem.m['h10]);
		chk("n sar", 32'h10c, mem.m['h11]);
		chk("n dar", 32'h20c, mem.m['h12]);
		chk("n cnt", 32'h0, mem.m['h13]);
		chk("n data", 32'h1000_0042, mem.m['h82]);
		mem.m['h13] = 32'h0001_0000;
		arm(1, 'h10);
		fire(1);
		chk("n again", 32'h210, mem.m['h12]);
	endtask : t_normal
	task t_repeat;
		info('h14, 8'h68, 8'h18, 32'h140, 32'h240, 32'h0202_0000);
		arm(3, 'h14);
		fire(3);
		chk("r sar1", 32'h144, mem.m['h15]);
		fire(3);
		chk("r sar", 32'h140, mem.m['h15]);
		chk("r dar", 32'h248, mem.m['h16]);
		chk("r cnt", 32'h0202_0000, mem.m['h17]);
		chk("r data", 32'h1000_0051, mem.m['h91]);
		en(3, 1'b1);
	endtask : t_repeat
	task t_block;
		slow <= 2'h3;
		info('h20, 8'ha8, 8'h08, 32'h300, 32'h280, 32'h1414_0002);
		arm(5, 'h20);
		fire(5);
		chk("b dar1", 32'h280, mem.m['h22]);
		chk("b cnt1", 32'h1414_0001, mem.m['h23]);
		en(5, 1'b1);
		fire(5);
		chk("b sar", 32'h3a0, mem.m['h21]);
		chk("b dar", 32'h280, mem.m['h22]);
		chk("b cnt", 32'h1414_0000, mem.m['h23]);
		chk("b first", 32'h1000_00d4, mem.m['ha0]);
		chk("b last", 32'h1000_00e7, mem.m['hb3]);
		en(5, 1'b0);
		slow <= 2'h0;
	endtask : t_block
	task t_chain;
		info('h18, 8'h28, 8'h88, 32'h1c0, 32'h3c0, 32'h0001_0000);
		info('h1c, 8'h20, 8'h00, 32'h1d0, 32'h3d0, 32'h0001_0000);
		arm(7, 'h18);
		fire(7);
		chk("c data0", 32'h1000_0070, mem.m['hf0]);
		chk("c data1", 32'h1000_0074, mem.m['hf4]);
		chk("c sar0", 32'h1c4, mem.m['h19]);
		chk("c sar1", 32'h1d0, mem.m['h1d]);
		chk("c dar1", 32'h3d0, mem.m['h1e]);
		en(7, 1'b0);
	endtask : t_chain
	task t_modes;
		info('h24, 8'h5c, 8'hc8, 32'h1e0, 32'h3e0, 32'h0101_0000);
		info('h28, 8'h28, 8'h08, 32'h1f0, 32'h3f0, 32'h0001_0000);
		arm(2, 'h24);
		// Frozen clock enable must not latch the request
		@(posedge clk);
		ce <= 1'b0;
		act_req[2] <= 1'b1;
		repeat (3) @(posedge clk);
		act_req[2] <= 1'b0;
		@(posedge clk);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		chk("frozen busy", 32'h0, {31'h0, busy});
		rchk(OFF_STATUS, 32'h0000_0007);
		fire(2);
		chk("m mode", 32'h5cc8_0000, mem.m['h24]);
		chk("m sar", 32'h1de, mem.m['h25]);
		chk("m dar", 32'h3e0, mem.m['h26]);
		chk("m cnt", 32'h0101_0000, mem.m['h27]);
		chk("m data", 32'h1000_0078, mem.m['hf8]);
		chk("m no chain", 32'h1f0, mem.m['h29]);
		en(2, 1'b1);
	endtask : t_modes
	task t_reset;
		avs_byteenable <= 4'h3;
		bus(1'b1, OFF_VBASE, 32'h1234_5678);
		avs_byteenable <= 4'hf;
		rchk(OFF_VBASE, 32'h0000_5678);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chk("rst wait", 32'h1, {31'h0, avs_waitrequest});
		chk("rst busy", 32'h0, {31'h0, busy});
		rchk(OFF_VBASE, VBASE_RST);
		en(2, 1'b0);
	endtask : t_reset
	task results;
		$display("miscompares=%0d checked=%0d", miscompares, checked);
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	// --------
	// Run
	// --------
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem.m[i] = 32'h1000_0000 + 32'(i);
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		t_regs;
		t_normal;
		t_repeat;
		t_block;
		t_chain;
		t_modes;
		t_reset;
		results;
	end
endmodule : tb
`default_nettype wire
